// ===== design/ist_params.svh
/*
 holds the register offsets, field positions, reset values and counts of
 the interval, square-wave and event timer.
 assumes it is included by its bare name before the package and modules.
*/
`ifndef IST_PARAMS_SVH
`define IST_PARAMS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IST_OFF_MODE 8'h00
`define IST_OFF_PRM 8'h04
`define IST_OFF_TOC 8'h08
`define IST_OFF_CMP1 8'h0c
`define IST_OFF_CMP2 8'h10
`define IST_OFF_CNT 8'h14
`define IST_OFF_PDIR 8'h18
`define IST_OFF_LATCH 8'h1c
`define IST_OFF_STAT 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define IST_MODE_LSB 2
`define IST_CKS_LSB 0
`define IST_ES_LSB 4
`define IST_TOC_OE 0
`define IST_TOC_INV1 1
`define IST_TOC_LVR 2
`define IST_TOC_LVS 3
`define IST_TOC_INV2 4
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define IST_PDIR_RST 8'hff
`define IST_PRM_RST 8'h00
`define IST_TOC_RST 8'h00
`define IST_LATCH_RST 8'h00
`define IST_DIV4_LAST 2'h3
`endif

// ===== design/ist_pkg.sv
/*
 holds the types of the interval, square-wave and event timer.
 assumes ist_params.svh supplies the numeric constants.
*/
package ist_pkg;
   // ----------------------------------------
   // enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_STOP, MODE_FREE, MODE_EDGE_CLR, MODE_MATCH_CLR} ist_mode_e;
   typedef enum logic [1:0] {CKS_PCLK, CKS_DIV4, CKS_ALT, CKS_EVENT} ist_cks_e;
   typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BAD, EDGE_BOTH} ist_edge_e;
   // ----------------------------------------
   // output control fields
   // ----------------------------------------
   typedef struct packed {
      logic inv2;
      logic inv1;
      logic oe;
   } ist_toc_s;
endpackage

// ===== design/ist_edge_filter.sv
/*
 holds the pin synchroniser, two-sample noise filter and edge selector.
 assumes pin_in is asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ist_edge_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_in,
   input wire ist_pkg::ist_edge_e edge_sel,
   output logic level,
   output logic valid_edge
);
   import ist_pkg::*;
   logic sync1_reg;
   logic sync2_reg;
   logic samp_reg;
   logic lvl_next;

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // ----------------------------------------
   // filter and edge select
   // ----------------------------------------
   // a level is accepted only once two samples agree
   assign lvl_next = (sync2_reg == samp_reg) ? samp_reg : level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_reg <= 1'b0;
         level <= 1'b0;
         valid_edge <= 1'b0;
      end else begin
         samp_reg <= sync2_reg;
         level <= lvl_next;
         case (edge_sel)
            EDGE_FALL: valid_edge <= level & ~lvl_next;
            EDGE_RISE: valid_edge <= ~level & lvl_next;
            EDGE_BOTH: valid_edge <= level ^ lvl_next;
            default: valid_edge <= 1'b0;
         endcase
      end
   end
endmodule // ist_edge_filter
`default_nettype wire

// ===== design/ist_timer.sv
/*
 holds the top of the interval, square-wave and event timer with its
 apb register file and the two shared port pins.
 assumes a single pclk domain; pins are resolved outside from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ist_params.svh"
module ist_timer #(
   parameter int CW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic port_pin_zero_in,
   output logic port_pin_zero_out,
   output logic port_pin_zero_oe_n,
   input wire logic port_pin_one_in,
   output logic port_pin_one_out,
   output logic port_pin_one_oe_n,
   input wire logic alt_clk_in,
   output logic first_match_irq,
   output logic second_match_irq,
   output logic timer_output_pin
);
   import ist_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   ist_mode_e mode_reg;
   logic [7:0] prm_reg;
   ist_toc_s toc_reg;
   logic [CW-1:0] cmp1_reg;
   logic [CW-1:0] cmp2_reg;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [7:0] pdir_reg;
   logic [7:0] latch_reg;
   logic [1:0] div_reg;
   logic armed_reg;
   logic tout_reg;
   logic tout_next;
   logic p1_sync1_reg;
   logic p1_sync2_reg;
   logic wr_en;
   logic setup;
   logic tick;
   logic running;
   logic hit1;
   logic hit2;
   logic evt_level;
   logic evt_edge;
   logic alt_edge;
   logic [31:0] rd_val;
   logic rd_ok;
   ist_cks_e cks;
   ist_edge_e es;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge8 = s[0] ? d[7:0] : old;
   endfunction

   function automatic logic [CW-1:0] merge16(input logic [CW-1:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      logic [CW-1:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[CW-1:8] = d[CW-1:8];
      end
      merge16 = r;
   endfunction

   assign setup = psel & ~penable;
   // a write lands only at the edge that also completes the access
   assign wr_en = psel & penable & pwrite & pready;
   assign cks = ist_cks_e'(prm_reg[`IST_CKS_LSB +: 2]);
   assign es = ist_edge_e'(prm_reg[`IST_ES_LSB +: 2]);
   assign running = (mode_reg != MODE_STOP);

   // ----------------------------------------
   // pin filters
   // ----------------------------------------
   ist_edge_filter u_evt (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(port_pin_zero_in),
      .edge_sel(es),
      .level(evt_level),
      .valid_edge(evt_edge)
   );

   // the alternate clock is oversampled, so it must run well below pclk/4
   ist_edge_filter u_alt (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(alt_clk_in),
      .edge_sel(EDGE_RISE),
      .level(),
      .valid_edge(alt_edge)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p1_sync1_reg <= 1'b0;
         p1_sync2_reg <= 1'b0;
      end else begin
         p1_sync1_reg <= port_pin_one_in;
         p1_sync2_reg <= p1_sync1_reg;
      end
   end

   // ----------------------------------------
   // count clock select
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 2'h0;
      end else if (!running) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end

   always_comb begin
      case (cks)
         CKS_PCLK: tick = running;
         CKS_DIV4: tick = running & (div_reg == `IST_DIV4_LAST);
         CKS_ALT: tick = running & alt_edge;
         CKS_EVENT: tick = running & evt_edge;
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------
   // start of event counting
   // ----------------------------------------
   // the first event edge after start only arms the counter, which is
   // why the first match takes one edge more than later ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg <= 1'b0;
      end else if (!running) begin
         armed_reg <= 1'b0;
      end else if (tick) begin
         armed_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // counter and compares
   // ----------------------------------------
   always_comb begin
      hit1 = 1'b0;
      hit2 = 1'b0;
      cnt_next = cnt_reg;
      if (!running) begin
         cnt_next = '0;
      end else if (tick && (cks != CKS_EVENT || armed_reg)) begin
         hit1 = (cnt_reg == cmp1_reg);
         hit2 = (cnt_reg == cmp2_reg);
         if (mode_reg == MODE_MATCH_CLR && hit1) begin
            cnt_next = '0;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // one pulse per count tick, so a held match never repeats
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_match_irq <= 1'b0;
         second_match_irq <= 1'b0;
      end else begin
         first_match_irq <= hit1;
         second_match_irq <= hit2;
      end
   end

   // ----------------------------------------
   // timer output
   // ----------------------------------------
   always_comb begin
      tout_next = tout_reg;
      if (wr_en && hit(paddr, `IST_OFF_TOC) && pstrb[0] && pwdata[`IST_TOC_LVR]) begin
         tout_next = 1'b0;
      end else if (wr_en && hit(paddr, `IST_OFF_TOC) && pstrb[0] && pwdata[`IST_TOC_LVS]) begin
         tout_next = 1'b1;
      end else if (toc_reg.oe) begin
         tout_next = tout_reg ^ (hit1 & toc_reg.inv1) ^ (hit2 & toc_reg.inv2);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tout_reg <= 1'b0;
         timer_output_pin <= 1'b0;
      end else begin
         tout_reg <= tout_next;
         timer_output_pin <= toc_reg.oe & tout_next;
      end
   end

   // ----------------------------------------
   // port pins
   // ----------------------------------------
   // oe_n follows the direction bit: 0 drives, 1 releases the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_pin_zero_out <= 1'b0;
         port_pin_one_out <= 1'b0;
         port_pin_zero_oe_n <= 1'b1;
         port_pin_one_oe_n <= 1'b1;
      end else begin
         port_pin_zero_out <= latch_reg[0];
         port_pin_one_out <= latch_reg[1] | (toc_reg.oe & tout_next);
         port_pin_zero_oe_n <= pdir_reg[0];
         port_pin_one_oe_n <= pdir_reg[1];
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_STOP;
      end else if (wr_en && hit(paddr, `IST_OFF_MODE) && pstrb[0]) begin
         mode_reg <= ist_mode_e'(pwdata[`IST_MODE_LSB +: 2]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prm_reg <= `IST_PRM_RST;
      end else if (wr_en && hit(paddr, `IST_OFF_PRM) && !running) begin
         prm_reg <= merge8(prm_reg, pwdata, pstrb);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toc_reg <= ist_toc_s'(3'(`IST_TOC_RST));
      end else if (wr_en && hit(paddr, `IST_OFF_TOC) && pstrb[0]) begin
         toc_reg.oe <= pwdata[`IST_TOC_OE];
         toc_reg.inv1 <= pwdata[`IST_TOC_INV1];
         toc_reg.inv2 <= pwdata[`IST_TOC_INV2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp1_reg <= '1;
         cmp2_reg <= '1;
      end else if (wr_en) begin
         if (hit(paddr, `IST_OFF_CMP1)) begin
            cmp1_reg <= merge16(cmp1_reg, pwdata, pstrb);
         end
         if (hit(paddr, `IST_OFF_CMP2)) begin
            cmp2_reg <= merge16(cmp2_reg, pwdata, pstrb);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdir_reg <= `IST_PDIR_RST;
         latch_reg <= `IST_LATCH_RST;
      end else if (wr_en) begin
         if (hit(paddr, `IST_OFF_PDIR)) begin
            pdir_reg <= merge8(pdir_reg, pwdata, pstrb);
         end
         if (hit(paddr, `IST_OFF_LATCH)) begin
            latch_reg <= merge8(latch_reg, pwdata, pstrb);
         end
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      case (paddr)
         `IST_OFF_MODE: rd_val[`IST_MODE_LSB +: 2] = mode_reg;
         `IST_OFF_PRM: rd_val[7:0] = prm_reg;
         `IST_OFF_TOC: begin
            rd_val[`IST_TOC_OE] = toc_reg.oe;
            rd_val[`IST_TOC_INV1] = toc_reg.inv1;
            rd_val[`IST_TOC_INV2] = toc_reg.inv2;
         end
         `IST_OFF_CMP1: rd_val[CW-1:0] = cmp1_reg;
         `IST_OFF_CMP2: rd_val[CW-1:0] = cmp2_reg;
         `IST_OFF_CNT: rd_val[CW-1:0] = cnt_reg;
         `IST_OFF_PDIR: rd_val[7:0] = pdir_reg;
         `IST_OFF_LATCH: rd_val[7:0] = latch_reg;
         `IST_OFF_STAT: rd_val[3:0] = {p1_sync2_reg, evt_level, tout_reg, running};
         default: rd_ok = 1'b0;
      endcase
   end

   // ----------------------------------------
   // apb answer
   // ----------------------------------------
   // data is captured in setup, so the access phase always ends in one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         pready <= 1'b1;
         pslverr <= ~rd_ok;
         prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule // ist_timer
`default_nettype wire

// ===== testbench/ist_timer_assertions.sv
/*
 concurrent checks on the ports of ist_timer, with small shadows of the
 mode, prescaler, output control, compare and direction registers.
 assumes one pclk domain and apb writes as the design takes them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ist_params.svh"
module ist_timer_assertions #(
   parameter int CW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic port_pin_zero_in,
   input wire logic port_pin_zero_out,
   input wire logic port_pin_zero_oe_n,
   input wire logic port_pin_one_in,
   input wire logic port_pin_one_out,
   input wire logic port_pin_one_oe_n,
   input wire logic alt_clk_in,
   input wire logic first_match_irq,
   input wire logic second_match_irq,
   input wire logic timer_output_pin
);
   // ----------------------------------------
   // register shadows
   // ----------------------------------------
   logic [1:0] mode_sh, cks_sh, pdir_sh, idle;
   logic [2:0] toc_sh;
   logic [15:0] cmp1_sh;
   logic [19:0] gap;
   logic seen;
   wire wr_ok = psel & penable & pready & pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sh <= 2'h0;
         cks_sh <= 2'h0;
         pdir_sh <= 2'h3;
         toc_sh <= 3'h0;
         cmp1_sh <= 16'hffff;
      end else if (wr_ok) begin
         if (pstrb[0] && paddr == `IST_OFF_MODE) mode_sh <= pwdata[3:2];
         // prescaler writes while running are dropped by the design too
         if (pstrb[0] && paddr == `IST_OFF_PRM && mode_sh == 2'h0) cks_sh <= pwdata[1:0];
         if (pstrb[0] && paddr == `IST_OFF_TOC) toc_sh <= {pwdata[4], pwdata[1:0]};
         if (pstrb[0] && paddr == `IST_OFF_PDIR) pdir_sh <= pwdata[1:0];
         if (pstrb[0] && paddr == `IST_OFF_CMP1) cmp1_sh[7:0] <= pwdata[7:0];
         if (pstrb[1] && paddr == `IST_OFF_CMP1) cmp1_sh[15:8] <= pwdata[15:8];
      end
   end
   // seen: a match already passed since the last write, so the gap is a full period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap <= 20'h0;
         seen <= 1'b0;
         idle <= 2'h0;
      end else begin
         gap <= first_match_irq ? 20'h1 : gap + 20'h1;
         seen <= wr_ok ? 1'b0 : (first_match_irq | seen);
         idle <= (mode_sh != 2'h0) ? 2'h0 : ((idle == 2'h3) ? idle : idle + 2'h1);
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_square_match;
      first_match_irq && seen && toc_sh == 3'h3;
   endsequence
   a_irq1_single: assert property (first_match_irq |=> !first_match_irq)
      else $error("first match request longer than one cycle");
   a_irq2_single: assert property (second_match_irq |=> !second_match_irq)
      else $error("second match request longer than one cycle");
   a_match_period: assert property (first_match_irq && seen && mode_sh == 2'h3 && cks_sh < 2'h2
      |-> gap == ((cks_sh == 2'h1) ? {2'h0, cmp1_sh, 2'h0} + 20'h4 : {4'h0, cmp1_sh} + 20'h1))
      else $error("match period differs from compare plus one ticks");
   a_square_toggle: assert property (s_square_match |-> ##1 timer_output_pin != $past(timer_output_pin, 2))
      else $error("timer output not inverted on first match");
   a_output_off_low: assert property (!toc_sh[0] && !$past(toc_sh[0]) |-> !timer_output_pin)
      else $error("timer output high while output disabled");
   a_count_read: assert property (pready && !pwrite && paddr == `IST_OFF_CNT && mode_sh == 2'h3
      |-> prdata[31:16] == 16'h0 && prdata[15:0] <= cmp1_sh)
      else $error("counter read beyond compare value");
   a_dir_follow: assert property (pdir_sh == $past(pdir_sh)
      |-> {port_pin_one_oe_n, port_pin_zero_oe_n} == pdir_sh)
      else $error("pin enables differ from direction bits");
   a_dir_reset: assert property ($rose(presetn) |-> port_pin_zero_oe_n && port_pin_one_oe_n)
      else $error("pins not inputs after reset");
   a_stop_quiet: assert property (idle == 2'h3 |-> !first_match_irq && !second_match_irq)
      else $error("match request while stopped");
endmodule // ist_timer_assertions
bind ist_timer ist_timer_assertions #(.CW(CW)) u_ist_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .port_pin_zero_in(port_pin_zero_in),
   .port_pin_zero_out(port_pin_zero_out), .port_pin_zero_oe_n(port_pin_zero_oe_n),
   .port_pin_one_in(port_pin_one_in), .port_pin_one_out(port_pin_one_out),
   .port_pin_one_oe_n(port_pin_one_oe_n), .alt_clk_in(alt_clk_in), .first_match_irq(first_match_irq),
   .second_match_irq(second_match_irq), .timer_output_pin(timer_output_pin));
`default_nettype wire

// ===== testbench/ist_pin_model.sv
/*
 pin model: event source on pin zero, pulled-up load on pin one.
 assumes the bench calls pulse from its main sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module ist_pin_model (
   input wire logic pclk,
   input wire logic pin0_out,
   input wire logic pin0_oe_n,
   input wire logic pin1_out,
   input wire logic pin1_oe_n,
   output logic pin0_wire,
   output logic pin1_wire
);
   logic ev = 1'b0;
   // source drives only a pin set as input
   assign pin0_wire = pin0_oe_n ? ev : pin0_out;
   // released pin floats to the pull-up, driven pin carries latch bit 1 ORed with the timer output
   assign pin1_wire = pin1_oe_n ? 1'b1 : pin1_out;
   // idles low so starting never sees a false rising edge; width 1 is noise
   task pulse(input int hi);
      @(posedge pclk);
      ev <= 1'b1;
      repeat (hi) @(posedge pclk);
      ev <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
endmodule // ist_pin_model
`default_nettype wire

// ===== testbench/ist_timer_tb.sv
/*
 self-checking bench for ist_timer: register table, count clocks,
 square wave, event counting and a reset in mid-run.
 assumes the checker is bound and ist_pin_model resolves the pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ist_params.svh"
module ist_timer_tb;
   import ist_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] x; logic e;} ist_row_s;
   localparam int EC = 1;
   logic pclk, presetn, psel, penable, pwrite, alt_clk_in, pready, pslverr, er, v;
   logic p0_in, p0_out, p0_oen, p1_in, p1_out, p1_oen, irq1, irq2, tout;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   int num_errors = 0, total_checks = 0, cyc = 0, n1 = 0, n2 = 0, last1 = 0, last2 = 0, gap1 = 0, gap2 = 0;
   int e, base;
   logic mask2 = 1'b0;
   int mul[3] = '{1, 4, 6};
   int ep[3] = '{1, 1, 2};
   logic [1:0] es[3] = '{2'h0, 2'h1, 2'h3};
   ist_row_s rows[10] = '{
      '{`IST_OFF_PDIR, 32'h0, 4'h0, 32'hff, 1'b0},
      '{`IST_OFF_PDIR, 32'ha5, 4'h1, 32'ha5, 1'b0},
      '{`IST_OFF_CMP1, 32'h1234, 4'hf, 32'h1234, 1'b0},
      '{`IST_OFF_CMP1, 32'h56, 4'h1, 32'h1256, 1'b0},
      '{`IST_OFF_CMP2, 32'habcd, 4'hf, 32'habcd, 1'b0},
      '{`IST_OFF_CNT, 32'h77, 4'hf, 32'h0, 1'b0},
      '{`IST_OFF_TOC, 32'h0b, 4'hf, 32'h03, 1'b0},
      '{`IST_OFF_PRM, 32'h31, 4'hf, 32'h31, 1'b0},
      '{`IST_OFF_LATCH, 32'h02, 4'hf, 32'h02, 1'b0},
      '{8'h40, 32'h1, 4'hf, 32'h0, 1'b1}};
   ist_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_pin_zero_in(p0_in), .port_pin_zero_out(p0_out), .port_pin_zero_oe_n(p0_oen),
      .port_pin_one_in(p1_in), .port_pin_one_out(p1_out), .port_pin_one_oe_n(p1_oen),
      .alt_clk_in(alt_clk_in), .first_match_irq(irq1), .second_match_irq(irq2), .timer_output_pin(tout));
   ist_pin_model pm (.pclk(pclk), .pin0_out(p0_out), .pin0_oe_n(p0_oen), .pin1_out(p1_out),
      .pin1_oe_n(p1_oen), .pin0_wire(p0_in), .pin1_wire(p1_in));
   // ----------------------------------------
   // clocks and match monitor
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // alternate clock: rising edge every 6 pclk, wide enough for the filter
   initial begin
      alt_clk_in = 1'b0;
      forever begin
         repeat (3) @(posedge pclk);
         alt_clk_in <= ~alt_clk_in;
      end
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (irq1 === 1'b1) begin
         n1 <= n1 + 1;
         gap1 <= cyc - last1;
         last1 <= cyc;
      end
      if (irq2 === 1'b1 && !mask2) begin
         n2 <= n2 + 1;
         gap2 <= cyc - last2;
         last2 <= cyc;
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task wrap_up;
      if (num_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
         num_errors++;
         wrap_up;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, 4'hf);
      chk(rd, x);
   endtask
   // wait until the match count reaches n, bounded
   task wirq(input int n);
      int k;
      k = 0;
      while (n1 < n && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 3000) begin
         num_errors++;
         wrap_up;
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk({p1_oen, p0_oen, tout, irq1}, 4'hc);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
         chk({31'h0, er}, {31'h0, rows[i].e});
         apb(1'b0, rows[i].a, 32'h0, 4'hf);
         chk({31'h0, er}, {31'h0, rows[i].e});
         if (!rows[i].e) chk(rd, rows[i].x);
      end
      chk({p1_oen, p0_oen}, 2'h1);
      wr(`IST_OFF_LATCH, 32'h1);
      rdc(`IST_OFF_LATCH, 32'h1);
      chk({31'h0, p0_out}, 32'h1);
      // interval timing on each count clock but the event pin; compare never zero
      wr(`IST_OFF_TOC, 32'h0);
      wr(`IST_OFF_CMP1, 32'h3);
      wr(`IST_OFF_CMP2, 32'h2);
      for (int c = 0; c < 3; c++) begin
         wr(`IST_OFF_MODE, 32'h0);
         wr(`IST_OFF_PRM, c);
         wr(`IST_OFF_MODE, 32'hc);
         wirq(n1 + 3);
         chk(gap1, mul[c] * 4);
         chk(gap2, mul[c] * 4);
         apb(1'b0, `IST_OFF_CNT, 32'h0, 4'hf);
         chk({31'h0, rd[15:0] <= 16'h3}, 32'h1);
      end
      wr(`IST_OFF_PRM, 32'h0);
      rdc(`IST_OFF_PRM, 32'h2);
      wr(`IST_OFF_MODE, 32'h0);
      rdc(`IST_OFF_CNT, 32'h0);
      base = n1;
      repeat (20) @(posedge pclk);
      chk(n1, base);
      // free run: the count passes the first compare once without clearing
      wr(`IST_OFF_MODE, 32'h4);
      repeat (60) @(posedge pclk);
      apb(1'b0, `IST_OFF_CNT, 32'h0, 4'hf);
      chk({31'h0, rd[15:0] > 16'h3}, 32'h1);
      chk(n1, base + 1);
      wr(`IST_OFF_MODE, 32'h0);
      // square wave on pin one: direction and latch cleared
      wr(`IST_OFF_LATCH, 32'h0);
      wr(`IST_OFF_PDIR, 32'hfd);
      wr(`IST_OFF_CMP1, 32'h4);
      wr(`IST_OFF_TOC, 32'h3);
      wr(`IST_OFF_MODE, 32'hc);
      wirq(n1 + 2);
      repeat (2) @(posedge pclk);
      v = tout;
      chk({31'h0, p1_in}, {31'h0, tout});
      wirq(n1 + 1);
      repeat (2) @(posedge pclk);
      chk({31'h0, tout}, {31'h0, ~v});
      wr(`IST_OFF_TOC, 32'h2);
      wirq(n1 + 2);
      chk({31'h0, tout}, 32'h0);
      // event counting, never with mode 10, noise pulse before each counted pulse
      wr(`IST_OFF_MODE, 32'h0);
      wr(`IST_OFF_TOC, 32'h0);
      wr(`IST_OFF_CMP1, EC);
      wr(`IST_OFF_CMP2, 32'hffff);
      // second compare unused from here, so its request is masked
      mask2 <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         wr(`IST_OFF_PRM, {26'h0, es[m], 4'h3});
         wr(`IST_OFF_MODE, 32'hc);
         base = n1;
         e = 0;
         for (int p = 0; p < 5; p++) begin
            pm.pulse(1);
            pm.pulse(4);
            e += ep[m];
            chk(n1 - base, (e < EC + 2) ? 0 : (e - EC - 2) / (EC + 1) + 1);
         end
         wr(`IST_OFF_MODE, 32'h0);
      end
      // reset while running
      wr(`IST_OFF_MODE, 32'hc);
      repeat (6) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({p1_oen, p0_oen, tout}, 3'h6);
      rdc(`IST_OFF_PDIR, 32'hff);
      rdc(`IST_OFF_CMP1, 32'hffff);
      rdc(`IST_OFF_MODE, 32'h0);
      wrap_up;
   end
endmodule // ist_timer_tb
`default_nettype wire
